// [ring_access_assertions.sv]
// checker for the access-ring block: bus handshake and token/ack timing.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ring_access_assertions (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       rx_valid,
	input wire logic       rx_ok,
	input wire logic [7:0] rx_source,
	input wire logic [7:0] rx_token_byte,
	input wire logic       token_release,
	input wire logic       token_held,
	input wire logic       token_tx_valid,
	input wire logic [7:0] token_tx_addr,
	input wire logic       frame_status_valid,
	input wire logic       frame_status_ok,
	input wire logic       ack_send,
	input wire logic [7:0] ack_dest
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_bus_answer_next: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered in the next cycle");
	a_bus_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_release_send_two: assert property (
		token_release && token_held |-> ##2 token_tx_valid)
		else $error("token frame not sent two cycles after release");
	a_send_drops_hold: assert property (token_tx_valid |-> !token_held)
		else $error("token still held while token frame sent");
	a_hold_fall_send: assert property ($fell(token_held) |-> token_tx_valid)
		else $error("token dropped without a token frame");
	a_addr_in_range: assert property (
		token_tx_valid |-> token_tx_addr != 8'h00 && token_tx_addr != 8'hFF)
		else $error("token sent to a reserved station number");
	a_addr_holds: assert property ($changed(token_tx_addr) |-> token_tx_valid)
		else $error("token address changed outside a send");
	a_ack_after_poll: assert property (
		ack_send |-> $past(rx_valid) && $past(rx_ok) && $past(rx_token_byte) == 8'hFF)
		else $error("poll acknowledge without a poll frame");
	a_ack_to_poller: assert property (ack_send |-> ack_dest == $past(rx_source))
		else $error("poll acknowledge sent to the wrong station");
	a_status_single: assert property (frame_status_valid |=> !frame_status_valid)
		else $error("frame outcome reported twice");
	// main scenarios
	c_token_sent: cover property (token_tx_valid);
	c_wrap_to_one: cover property (token_tx_valid && token_tx_addr == 8'h01);
	c_poll_acked: cover property (ack_send);
	c_data_timeout: cover property (frame_status_valid && !frame_status_ok);
endmodule
`default_nettype wire

// [ring_access_consts.vh]
// constants for the access-ring maintenance block: register map, field
// positions, reset values, station numbers and timing figures.
// assumes it is included by its bare name from the design file.
`ifndef RING_ACCESS_CONSTS_VH
`define RING_ACCESS_CONSTS_VH

// ----------------------------------------------------------------------
// register word indexes (byte address = 4 * index)
// ----------------------------------------------------------------------
`define REG_CTRL          4'h0
`define REG_OWN           4'h1
`define REG_NAR           4'h2
`define REG_SUCC          4'h3
`define REG_IRQ_STATUS    4'h4
`define REG_IRQ_MASK      4'h5
`define REG_ACK_TIME      4'h6

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_NET_ENABLE   0
`define CTRL_ISOLATE      1
`define CTRL_JOIN_REQ     2
`define CTRL_RX_ONLY      3
`define CTRL_START_TOKEN  4
`define CTRL_WIDTH        5
`define NAR_FLAG_BIT      8
`define SUCC_SCAN_BIT     8
`define SUCC_HOLD_BIT     9
`define IRQ_RING_CHANGE   0
`define IRQ_SELF_ONLY     1
`define IRQ_DATA_TIMEOUT  2
`define IRQ_TOKEN_IN      3
`define IRQ_WIDTH         4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CTRL_RESET        5'h00
`define OWN_RESET         8'h01
`define IRQ_RESET         4'h0
`define ACK_TIME_RESET    16'h0064

// ----------------------------------------------------------------------
// station numbers and token control values
// ----------------------------------------------------------------------
`define STATION_NONE      8'h00
`define STATION_FIRST     8'h01
`define STATION_LAST      8'hFE
`define STATION_BCAST     8'hFF
`define TC_ACK_REQUEST    8'hFF

// ----------------------------------------------------------------------
// timing: the ack timer counts microsecond ticks
// ----------------------------------------------------------------------
`define CLK_MHZ           250
`define TICK_US           1
`define TICK_CYCLES       (`CLK_MHZ * `TICK_US)
`define TICK_CNT_LAST     8'hF9

`endif

// [ring_peer_model.sv]
// behavioural model of the peer stations on the shared medium.
// assumes the bench merges the answer frame into the rx inputs.
`timescale 1ns/10ps
`default_nettype none
module ring_peer_model (
	input  wire logic         mclk,
	input  wire logic         slow,
	input  wire logic [255:0] alive,
	input  wire logic         token_tx_valid,
	input  wire logic [7:0]   token_tx_addr,
	output var  logic         tx_done,
	output var  logic         resp_valid,
	output var  logic [7:0]   resp_source
);
	logic [7:0] log [$];
	logic [7:0] tgt;
	// one token frame at a time; the block never resends before its timer runs out
	initial begin
		tx_done = 1'b0;
		resp_valid = 1'b0;
		resp_source = 8'h00;
		forever begin
			@(posedge mclk);
			if (token_tx_valid === 1'b1) begin
				tgt = token_tx_addr;
				log.push_back(tgt);
				repeat (3) @(posedge mclk);
				tx_done <= 1'b1;
				@(posedge mclk);
				tx_done <= 1'b0;
				// a dead or isolated station stays silent
				if (alive[tgt]) begin
					repeat (slow ? 40 : 5) @(posedge mclk);
					resp_valid <= 1'b1;
					resp_source <= tgt;
					@(posedge mclk);
					resp_valid <= 1'b0;
					resp_source <= ~tgt; // released field shows no stale value
				end
			end
		end
	end
endmodule
`default_nettype wire

// [token_ring_access_recovery.v]
// access-ring maintenance: successor selection, failure scanning,
// scan control frames, poll acknowledge status and an Avalon-MM register
// slave with one level interrupt.
// assumes a frame receiver/transmitter beside it that reports decoded
// frames as one-cycle pulses and sends token and ack frames on request,
// all synchronous to mclk.
//
// Functional notes
// - entering networked state, successor comes from next-address request when flag set.
// - outside scan mode the token is addressed to the current successor station.
// - in scan mode, no answer from the addressed station means the next higher number is tried.
// - the first answering station is stored as successor for later passes.
// - scanning skips 0 and 255, stepping circularly 1 to 254.
// - in scan mode each candidate station gets exactly one token attempt.
// - two failed passes to the successor set it to plus one and start scanning.
// - a successor change caused by a network exception raises the ring-change interrupt.
// - a scan control frame sets successor to own number plus one, no host action.
// - scan frames addressed to own number or broadcast are both obeyed.
// - destination 255 is broadcast for every station; zero is reserved.
// - ack timer expiry with no answer after a token pass counts as failure.
// - timer restarts on transmission complete; valid frame from the addressed station is its answer.
// - recovery scans from failed successor plus one; startup from own plus one unless a next-address request is flagged.
// - an isolated station stops responding so peers drop it like a dead one.
// - host frame awaiting ack is abandoned at timer expiry, outcome reported, work continues.
// - poll acknowledge carries host-set join-request and receive-only bits and an in-ring bit that is the inverse of receive-only.
`timescale 1ns/10ps
`default_nettype none
`include "ring_access_consts.vh"

module token_ring_access_recovery (
	input  wire        mclk,
	input  wire        rst_n,
	// avalon-mm register slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg         irq,
	// decoded receive frames, one-cycle pulse with fields
	input  wire        rx_valid,
	input  wire        rx_ok,
	input  wire [7:0]  rx_source,
	input  wire [7:0]  rx_dest,
	input  wire [7:0]  rx_token_byte,
	input  wire        rx_scan,
	input  wire        rx_ack,
	// data transmission side
	input  wire        token_release,
	input  wire        tx_done,
	input  wire        data_ack_wait,
	input  wire [7:0]  data_dest,
	output reg         token_held,
	output reg         token_tx_valid,
	output reg  [7:0]  token_tx_addr,
	output reg         frame_status_valid,
	output reg         frame_status_ok,
	// poll acknowledge request to the transmitter
	output reg         ack_send,
	output reg  [7:0]  ack_dest,
	output reg  [2:0]  ack_status
);

	// ------------------------------------------------------------------
	// states
	// ------------------------------------------------------------------
	localparam [2:0] S_OFF    = 3'h0;
	localparam [2:0] S_LISTEN = 3'h1;
	localparam [2:0] S_HOLD   = 3'h2;
	localparam [2:0] S_SEND   = 3'h3;
	localparam [2:0] S_TXWAIT = 3'h4;
	localparam [2:0] S_RESP   = 3'h5;
	localparam [2:0] S_DWAIT  = 3'h6;

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------
	// next candidate station, circular over the usable range only
	function [7:0] next_station;
		input [7:0] s;
		begin
			if (s >= `STATION_LAST || s == `STATION_NONE)
				next_station = `STATION_FIRST;
			else
				next_station = s + `STATION_FIRST;
		end
	endfunction

	// destination match: own number or broadcast
	function for_us;
		input [7:0] dest;
		input [7:0] own;
		begin
			for_us = (dest == own) || (dest == `STATION_BCAST);
		end
	endfunction

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	reg [`CTRL_WIDTH-1:0] ctrl;
	reg [7:0]             own_station_number;
	reg [7:0]             next_addr_request;
	reg                   new_successor_flag;
	reg [7:0]             successor_station;
	reg                   scanning;
	reg [`IRQ_WIDTH-1:0]  irq_status;
	reg [`IRQ_WIDTH-1:0]  irq_mask;
	reg [15:0]            ack_time;

	reg [2:0]             state;
	reg [7:0]             target;
	reg                   second_try;
	reg                   net_q;
	reg [15:0]            ack_timer;
	reg [7:0]             tick_cnt;
	reg                   tick;
	reg [7:0]             wait_dest;

	wire net_on   = ctrl[`CTRL_NET_ENABLE];
	wire isolated = ctrl[`CTRL_ISOLATE];
	wire net_entry = net_on && !net_q;

	// a write completes at the edge where waitrequest is seen low; read data is loaded at the edge where it is still high
	wire wr_go = avs_write && !avs_waitrequest;
	wire rd_go = avs_read && avs_waitrequest;

	// frames that count: good check sequence, station not isolated (an answer from target needs only a good check sequence)
	wire rx_good = rx_valid && rx_ok && !isolated;
	wire rx_token_in = rx_good && (rx_token_byte == own_station_number);
	wire rx_scan_in  = rx_good && rx_scan && for_us(rx_dest, own_station_number);
	wire rx_poll_in  = rx_good && (rx_token_byte == `TC_ACK_REQUEST)
		&& for_us(rx_dest, own_station_number) && (rx_dest != `STATION_BCAST);
	wire rx_from_target = rx_valid && rx_ok && (rx_source == target);

	// timer runs out only on a tick so the count stays in microseconds
	wire timer_expired = tick && (ack_timer == 16'h0000);

	// events that set the sticky interrupt bits, built below
	reg [`IRQ_WIDTH-1:0] irq_set;
	wire [`IRQ_WIDTH-1:0] irq_clr =
		(wr_go && avs_address == `REG_IRQ_STATUS) ? avs_writedata[`IRQ_WIDTH-1:0] :
		{`IRQ_WIDTH{1'b0}};

	// ------------------------------------------------------------------
	// microsecond tick divider
	// ------------------------------------------------------------------
	// free running: a timeout may be up to one tick longer, which
	// is accepted against the cost of restarting the divider per pass
	always @(posedge mclk) begin
		if (!rst_n) begin
			tick_cnt <= 8'h00;
			tick     <= 1'b0;
		end else if (tick_cnt == `TICK_CNT_LAST) begin
			tick_cnt <= 8'h00;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 8'h01;
			tick     <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// avalon-mm slave handshake and read data
	// ------------------------------------------------------------------
	// one wait state: request seen, waitrequest drops, done next edge
	always @(posedge mclk) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			if ((avs_read || avs_write) && avs_waitrequest)
				avs_waitrequest <= 1'b0;
			else
				avs_waitrequest <= 1'b1;
			if (rd_go) begin
				case (avs_address)
				`REG_CTRL:       avs_readdata <= {27'h0, ctrl};
				`REG_OWN:        avs_readdata <= {24'h0, own_station_number};
				`REG_NAR:        avs_readdata <= {23'h0, new_successor_flag,
							next_addr_request};
				`REG_SUCC:       avs_readdata <= {22'h0, token_held, scanning,
							successor_station};
				`REG_IRQ_STATUS: avs_readdata <= {28'h0, irq_status};
				`REG_IRQ_MASK:   avs_readdata <= {28'h0, irq_mask};
				`REG_ACK_TIME:   avs_readdata <= {16'h0, ack_time};
				default:         avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// host-written configuration
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			ctrl               <= `CTRL_RESET;
			own_station_number <= `OWN_RESET;
			irq_mask           <= `IRQ_RESET;
			ack_time           <= `ACK_TIME_RESET;
			next_addr_request  <= `STATION_FIRST;
		end else if (wr_go) begin
			case (avs_address)
			`REG_CTRL:     ctrl <= avs_writedata[`CTRL_WIDTH-1:0];
			`REG_OWN:      own_station_number <= avs_writedata[7:0];
			`REG_NAR:      next_addr_request <= avs_writedata[7:0];
			`REG_IRQ_MASK: irq_mask <= avs_writedata[`IRQ_WIDTH-1:0];
			`REG_ACK_TIME: ack_time <= avs_writedata[15:0];
			default:       ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// interrupt status, mask and output
	// ------------------------------------------------------------------
	// a new event in the clear cycle survives: set wins over clear
	always @(posedge mclk) begin
		if (!rst_n) begin
			irq_status <= `IRQ_RESET;
			irq        <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			irq        <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
		end
	end

	// ------------------------------------------------------------------
	// poll acknowledge
	// ------------------------------------------------------------------
	// status bits are relayed without host involvement; an isolated
	// station never answers, so rx_poll_in stays low for it
	always @(posedge mclk) begin
		if (!rst_n) begin
			ack_send   <= 1'b0;
			ack_dest   <= `STATION_NONE;
			ack_status <= 3'h0;
		end else begin
			ack_send <= rx_poll_in && net_on;
			if (rx_poll_in && net_on) begin
				ack_dest   <= rx_source;
				ack_status <= {ctrl[`CTRL_JOIN_REQ], ctrl[`CTRL_RX_ONLY],
					!ctrl[`CTRL_RX_ONLY]};
			end
		end
	end

	// ------------------------------------------------------------------
	// interrupt events from the ring state machine
	// ------------------------------------------------------------------
	always @* begin
		irq_set = {`IRQ_WIDTH{1'b0}};
		if (state == S_RESP && !rx_from_target && timer_expired) begin
			if (scanning && next_station(target) == own_station_number)
				irq_set[`IRQ_SELF_ONLY] = 1'b1;
			else if (!scanning && second_try)
				irq_set[`IRQ_RING_CHANGE] = 1'b1;
		end
		if (state == S_RESP && rx_from_target && scanning
			&& target != successor_station)
			irq_set[`IRQ_RING_CHANGE] = 1'b1;
		if ((state == S_LISTEN || state == S_HOLD) && rx_scan_in)
			irq_set[`IRQ_RING_CHANGE] = 1'b1;
		if (state == S_DWAIT && timer_expired && !(rx_valid && rx_ok && rx_ack
			&& rx_source == wait_dest))
			irq_set[`IRQ_DATA_TIMEOUT] = 1'b1;
		if (state == S_LISTEN && rx_token_in)
			irq_set[`IRQ_TOKEN_IN] = 1'b1;
	end

	// ------------------------------------------------------------------
	// ring state machine
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			state              <= S_OFF;
			net_q              <= 1'b0;
			new_successor_flag <= 1'b0;
			successor_station  <= `STATION_FIRST;
			scanning           <= 1'b0;
			target             <= `STATION_FIRST;
			second_try         <= 1'b0;
			ack_timer          <= 16'h0000;
			wait_dest          <= `STATION_NONE;
			token_held         <= 1'b0;
			token_tx_valid     <= 1'b0;
			token_tx_addr      <= `STATION_NONE;
			frame_status_valid <= 1'b0;
			frame_status_ok    <= 1'b0;
		end else begin
			net_q              <= net_on;
			token_tx_valid     <= 1'b0;
			frame_status_valid <= 1'b0;
			// the ack timer counts down in microsecond ticks
			if (tick && ack_timer != 16'h0000)
				ack_timer <= ack_timer - 16'h0001;

			if (!net_on) begin
				state      <= S_OFF;
				token_held <= 1'b0;
				scanning   <= 1'b0;
			end else begin
				case (state)
				S_OFF: begin
					if (net_entry) begin
						// startup scan from request or own plus one
						if (new_successor_flag) begin
							successor_station  <= next_addr_request;
							new_successor_flag <= 1'b0;
						end else begin
							successor_station <= next_station(own_station_number);
						end
						scanning   <= 1'b1;
						second_try <= 1'b0;
						if (ctrl[`CTRL_START_TOKEN] && !isolated) begin
							state      <= S_HOLD;
							token_held <= 1'b1;
						end else begin
							state <= S_LISTEN;
						end
					end
				end
				S_LISTEN, S_HOLD: begin
					// host rewrites the successor between passes
					if (new_successor_flag) begin
						successor_station  <= next_addr_request;
						new_successor_flag <= 1'b0;
						scanning           <= 1'b0;
					end else if (rx_scan_in) begin
						successor_station <= next_station(own_station_number);
						scanning          <= 1'b1;
					end
					if (state == S_LISTEN) begin
						if (rx_token_in) begin
							state      <= S_HOLD;
							token_held <= 1'b1;
						end
					end else if (data_ack_wait) begin
						// host frame sent, wait for its ack
						wait_dest <= data_dest;
						ack_timer <= ack_time;
						state     <= S_DWAIT;
					end else if (token_release) begin
						target     <= successor_station;
						second_try <= 1'b0;
						state      <= S_SEND;
					end
				end
				S_DWAIT: begin
					if (rx_valid && rx_ok && rx_ack && rx_source == wait_dest) begin
						frame_status_valid <= 1'b1;
						frame_status_ok    <= 1'b1;
						state              <= S_HOLD;
					end else if (timer_expired) begin
						frame_status_valid <= 1'b1;
						frame_status_ok    <= 1'b0;
						state              <= S_HOLD;
					end
				end
				S_SEND: begin
					token_tx_valid <= 1'b1;
					token_tx_addr  <= target;
					token_held     <= 1'b0;
					state          <= S_TXWAIT;
				end
				S_TXWAIT: begin
					if (tx_done) begin
						ack_timer <= ack_time;
						state     <= S_RESP;
					end
				end
				S_RESP: begin
					if (rx_from_target) begin
						// the pass succeeded: remember who answered
						if (scanning)
							successor_station <= target;
						scanning   <= 1'b0;
						second_try <= 1'b0;
						state      <= S_LISTEN;
					end else if (timer_expired) begin
						if (scanning) begin
							// one try per candidate, then step on
							if (next_station(target) == own_station_number) begin
								// nobody else alive: keep the token
								successor_station <= next_station(own_station_number);
								token_held        <= 1'b1;
								state             <= S_HOLD;
							end else begin
								target <= next_station(target);
								state  <= S_SEND;
							end
						end else if (!second_try) begin
							second_try <= 1'b1;
							state      <= S_SEND;
						end else begin
							// start recovery just above the dead station
							successor_station <= next_station(target);
							target            <= next_station(target);
							scanning          <= 1'b1;
							second_try        <= 1'b0;
							if (next_station(target) == own_station_number) begin
								successor_station <= next_station(own_station_number);
								token_held <= 1'b1;
								state      <= S_HOLD;
							end else begin
								state <= S_SEND;
							end
						end
					end
				end
				default: state <= S_OFF;
				endcase
			end
			if (wr_go && avs_address == `REG_NAR && avs_writedata[`NAR_FLAG_BIT])
				new_successor_flag <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// [token_ring_access_recovery_tb_top.sv]
// bench for the access-ring block: register tasks, peer model, frame driver.
// assumes the constants header and a 250 MHz mclk.
`timescale 1ns/10ps
`default_nettype none
`include "ring_access_consts.vh"
module token_ring_access_recovery_tb_top;
	logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic b_valid, rx_ok, rx_scan, rx_ack, token_release, tx_done, data_ack_wait;
	logic [7:0] b_src, rx_dest, rx_token_byte, data_dest, own, ack_dest, token_tx_addr;
	logic resp_valid, token_held, token_tx_valid, frame_status_valid, frame_status_ok, ack_send;
	logic [7:0] resp_source;
	logic [2:0] ack_status;
	logic [255:0] alive;
	logic slow;
	int mismatches, num_checks, k;
	// bench frames and peer answers share the receive port
	wire rx_valid = b_valid | resp_valid;
	wire [7:0] rx_source = resp_valid ? resp_source : b_src;
	token_ring_access_recovery i_token_ring_access_recovery (.mclk, .rst_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
		.rx_valid, .rx_ok, .rx_source, .rx_dest, .rx_token_byte, .rx_scan, .rx_ack,
		.token_release, .tx_done, .data_ack_wait, .data_dest, .token_held, .token_tx_valid,
		.token_tx_addr, .frame_status_valid, .frame_status_ok, .ack_send, .ack_dest, .ack_status);
	ring_peer_model i_ring_peer_model (.mclk, .slow, .alive, .token_tx_valid, .token_tx_addr,
		.tx_done, .resp_valid, .resp_source);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one access, held until waitrequest is low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		rd = avs_readdata;
		if (n >= 100) check("bus_answer", 0, 1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task frame(input logic [7:0] s, d, t, input logic sc, ak);
		b_valid <= 1'b1;
		b_src <= s;
		rx_dest <= d;
		rx_token_byte <= t;
		rx_scan <= sc;
		rx_ack <= ak;
		@(posedge mclk);
		b_valid <= 1'b0;
		b_src <= ~s;
		rx_dest <= ~d;
		rx_token_byte <= 8'h00;
		rx_scan <= 1'b0;
		rx_ack <= 1'b0;
	endtask
	task tok(input logic [7:0] s);
		frame(s, own, own, 1'b0, 1'b0);
		@(posedge mclk);
		check("token_held", token_held, 1);
	endtask
	// release the token and compare every token frame the peers saw
	task run_pass(input int n, input logic [63:0] seq);
		int i, w;
		w = 0;
		token_release <= 1'b1;
		@(posedge mclk);
		token_release <= 1'b0;
		while (i_ring_peer_model.log.size() < n && w < 20000) begin
			@(posedge mclk);
			w++;
		end
		repeat (600) @(posedge mclk);
		check("token_count", i_ring_peer_model.log.size(), n);
		for (i = 0; i < n; i++) check("token_addr", i_ring_peer_model.log[i], seq[8*i+:8]);
		i_ring_peer_model.log.delete();
	endtask
	task wait_status(input logic exp);
		int w;
		w = 0;
		do begin
			@(posedge mclk);
			w++;
		end while (frame_status_valid !== 1'b1 && w < 3000);
		check("frame_status_ok", frame_status_ok, exp);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// the tests need under 20000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		mismatches++;
		print_verdict();
	end
	initial begin
		{rst_n, avs_read, avs_write, b_valid, rx_scan, rx_ack, token_release} = 0;
		{data_ack_wait, slow, avs_address, avs_writedata, b_src, rx_dest} = 0;
		{rx_token_byte, data_dest, mismatches, num_checks} = 0;
		rx_ok = 1'b1;
		alive = 256'h0;
		alive[20] = 1'b1;
		own = 8'h0A;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		bus(0, `REG_OWN, 0);
		check("own_reset", rd, 32'h01);
		bus(0, `REG_ACK_TIME, 0);
		check("ack_time_reset", rd, 32'h64);
		bus(0, 4'h7, 0);
		check("unmapped", rd, 32'h0);
		bus(1, `REG_SUCC, 32'h55);
		bus(0, `REG_SUCC, 0);
		check("succ_read_only", rd, 32'h01);
		$display("test reset done");
		bus(1, `REG_OWN, own);
		bus(1, `REG_ACK_TIME, 32'h1);
		bus(1, `REG_IRQ_MASK, 32'h1);
		bus(1, `REG_NAR, 32'h114);
		bus(1, `REG_CTRL, 32'h11);
		bus(0, `REG_SUCC, 0);
		check("succ_from_request", rd & 32'hFF, 20);
		check("start_token", token_held, 1);
		run_pass(1, 64'h14);
		$display("test start done");
		tok(20);
		alive[20] = 1'b0;
		alive[23] = 1'b1;
		slow = 1'b1;
		run_pass(5, 64'h17_1615_1414);
		bus(0, `REG_SUCC, 0);
		check("succ_found", rd & 32'hFF, 23);
		check("irq_ring_change", irq, 1);
		bus(1, `REG_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge mclk);
		check("irq_cleared", irq, 0);
		tok(23);
		run_pass(1, 64'h17);
		$display("test failover done");
		slow = 1'b0;
		for (k = 0; k < 3; k++) begin
			bus(1, `REG_NAR, 32'h117);
			frame(8'h04, k == 0 ? 8'h4D : (k == 1 ? own : 8'hFF), 8'h00, 1'b1, 1'b0);
			bus(0, `REG_SUCC, 0);
			check("scan_succ", rd & 32'hFF, k == 0 ? 23 : 11);
		end
		check("irq_scan", irq, 1);
		bus(1, `REG_IRQ_MASK, 32'h0);
		repeat (2) @(posedge mclk);
		check("irq_masked", irq, 0);
		bus(1, `REG_IRQ_STATUS, 32'hF);
		bus(1, `REG_IRQ_MASK, 32'h1);
		alive[12] = 1'b1;
		tok(23);
		run_pass(2, 64'h0C0B);
		$display("test scan frame done");
		for (k = 0; k < 2; k++) begin
			bus(1, `REG_CTRL, k == 0 ? 32'h15 : 32'h19);
			frame(8'h28, own, 8'hFF, 1'b0, 1'b0);
			@(posedge mclk);
			check("ack_send", ack_send, 1);
			check("ack_dest", ack_dest, 8'h28);
			check("ack_status", ack_status[2:1], k == 0 ? 2'b10 : 2'b01);
		end
		bus(1, `REG_NAR, 32'h128);
		bus(0, `REG_SUCC, 0);
		check("admit_joiner", rd & 32'hFF, 8'h28);
		$display("test poll done");
		tok(12);
		data_ack_wait <= 1'b1;
		data_dest <= 8'h1E;
		@(posedge mclk);
		data_ack_wait <= 1'b0;
		frame(8'h1E, own, 8'h00, 1'b0, 1'b1);
		wait_status(1'b1);
		data_ack_wait <= 1'b1;
		@(posedge mclk);
		data_ack_wait <= 1'b0;
		wait_status(1'b0);
		bus(0, `REG_IRQ_STATUS, 0);
		check("data_timeout_flag", rd & 32'h4, 32'h4);
		$display("test data ack done");
		bus(1, `REG_NAR, 32'h109);
		run_pass(2, 64'h0909);
		check("keep_token", token_held, 1);
		own = 8'hFA;
		bus(1, `REG_OWN, own);
		frame(8'h04, own, 8'h00, 1'b1, 1'b0);
		alive[2] = 1'b1;
		run_pass(6, 64'h0201_FEFD_FCFB);
		$display("test wrap done");
		bus(1, `REG_CTRL, 32'h13);
		frame(8'h28, own, 8'hFF, 1'b0, 1'b0);
		@(posedge mclk);
		check("isolated_silent", ack_send, 0);
		$display("test isolate done");
		print_verdict();
	end
endmodule
bind token_ring_access_recovery ring_access_assertions i_ring_access_assertions (.mclk, .rst_n,
	.avs_read, .avs_write, .avs_waitrequest, .rx_valid, .rx_ok, .rx_source, .rx_token_byte,
	.token_release, .token_held, .token_tx_valid, .token_tx_addr, .frame_status_valid,
	.frame_status_ok, .ack_send, .ack_dest);
`default_nettype wire
